// *** rtl/rxsec_pkg.sv ***
// Package for the receive signaling and error counter register group
package rxsec_pkg;
  // Register indices; each register is one aligned word, byte address = 4*index
  localparam logic [7:0] IDX_MW_CH1_8 = 8'h3c;
  localparam logic [7:0] IDX_MW_CH9_16 = 8'h3d;
  localparam logic [7:0] IDX_MW_CH17_24 = 8'h3e;
  localparam logic [7:0] IDX_SIG_FIRST = 8'h40;
  localparam logic [7:0] IDX_SIG_LAST = 8'h4f;
  localparam logic [7:0] IDX_LINE_HI = 8'h50;
  localparam logic [7:0] IDX_LINE_LO = 8'h51;
  localparam logic [7:0] IDX_PATH_HI = 8'h52;
  localparam logic [7:0] IDX_PATH_LO = 8'h53;
  localparam logic [7:0] IDX_SYNC_HI = 8'h54;
  localparam logic [7:0] IDX_SYNC_LO = 8'h55;
  localparam logic [7:0] IDX_EBIT_HI = 8'h56;
  localparam logic [7:0] IDX_EBIT_LO = 8'h57;
  localparam logic [7:0] IDX_FEA_HI = 8'h58;
  localparam logic [7:0] IDX_FEA_LO = 8'h59;
  localparam logic [7:0] IDX_MODE = 8'h5f;
  localparam int ADDR_LSB = 2;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Mu-law digital milliwatt sequence, eight bytes repeating
  localparam logic [63:0] MILLIWATT_SEQ = 64'h1e0b0b1e9e8b8b9e;
  localparam int T1_CHANNELS = 24;
  localparam int E1_CHANNELS = 30;

  typedef struct packed {
    logic t1_d4;
    logic e1;
  } rxsec_mode_t;

  typedef struct packed {
    logic [4:0] chan;
    logic [3:0] abcd;
    logic valid;
  } rxsec_sig_t;

  typedef struct packed {
    logic line_viol;
    logic path_viol;
    logic sync_loss;
    logic ebit_err;
    logic far_end_a;
  } rxsec_evt_t;
endpackage

// *** rtl/rxsec_top.sv ***
// Receive signaling registers, milliwatt substitution and 16-bit error counters
// Notes on behaviour
// [R1] A set milliwatt enable bit replaces that T1 channel's receive data with milliwatt code.
// [R2] Sixteen signaling byte registers sit at per-port offsets 0x40 to 0x4f.
// [R3] T1: reg k holds channel k and k+12; E1: reg1 upper zero, others 1-15/16-30.
// [R4] ESF reports A-D; D4 copies A and B into the C and D positions.
// [R5] Host reads signaling every 1.5 ms in D4 and every 3 ms in ESF.
// [R6] Signaling registers freeze while out of frame, holding the last good values.
// [R7] Line code violation count, 16 bits, hi at 0x50, lo at 0x51, reset zero.
// [R8] Path code violation count, 16 bits, hi at 0x52, lo at 0x53, reset zero.
// [R9] Frames out of sync count, 16 bits, hi at 0x54, lo at 0x55, reset zero.
// [R10] E-bit error count in E1 mode only, hi at 0x56, lo at 0x57.
// [R11] Far-end count A upper byte sits at 0x58.
// [R12] Far-end count A lower byte sits at 0x59.
// [R13] Counters saturate; reading hi snapshots lo so the pair never tears.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module rxsec_top #(
  parameter int CNT_W = 16
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rxsec_pkg::rxsec_sig_t SIG_IN,
  input wire logic OUT_OF_FRAME,
  input wire rxsec_pkg::rxsec_evt_t EVT_IN,
  input wire logic [4:0] RX_CHAN,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  output logic [7:0] RX_DATA_OUT,
  output logic RX_VALID_OUT,
  output rxsec_pkg::rxsec_mode_t MODE
);

  typedef logic [CNT_W-1:0] rxsec_cnt_t;

  typedef struct packed {
    logic [23:0] mw_en;
    rxsec_pkg::rxsec_mode_t mode;
    logic [15:0][7:0] sig;
    rxsec_cnt_t line_cnt;
    rxsec_cnt_t path_cnt;
    rxsec_cnt_t sync_cnt;
    rxsec_cnt_t ebit_cnt;
    rxsec_cnt_t fea_cnt;
    logic [7:0] lo_snap;
    logic [2:0] mw_phase;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rxsec_state_t;

  rxsec_state_t st;
  rxsec_state_t next_st;

  localparam rxsec_cnt_t SAT = rxsec_cnt_t'(rxsec_pkg::CNT_MAX);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  // Saturating increment keeps a stuck error source from wrapping to a small count
  function automatic rxsec_cnt_t sat_inc(input rxsec_cnt_t c, input logic ev);
    sat_inc = (ev && c != rxsec_cnt_t'(rxsec_pkg::CNT_MAX)) ? c + rxsec_cnt_t'(1) : c; // [R13]
  endfunction

  function automatic logic [7:0] hi_byte(input rxsec_cnt_t c);
    hi_byte = c[CNT_W-1:CNT_W-8];
  endfunction

  function automatic logic [7:0] lo_byte(input rxsec_cnt_t c);
    lo_byte = c[7:0];
  endfunction

  logic [7:0] idx;
  logic access_cyc;
  logic [3:0] abcd;
  logic [3:0] reg_sel;
  logic upper;
  logic [7:0] rd;
  logic rd_ok;

  assign idx = PADDR[rxsec_pkg::ADDR_LSB+7:rxsec_pkg::ADDR_LSB];
  assign access_cyc = PSEL && PENABLE;

  always_comb begin
    next_st = st;
    abcd = SIG_IN.abcd;
    reg_sel = 4'h0;
    upper = 1'b0;
    rd = 8'h00;
    rd_ok = 1'b1;
    // D4 carries only A and B; repeat them where C and D would sit
    if (!st.mode.e1 && st.mode.t1_d4) begin
      abcd = {SIG_IN.abcd[3:2], SIG_IN.abcd[3:2]}; // [R4]
    end
    // Channel to register/nibble mapping
    if (st.mode.e1) begin
      if (SIG_IN.chan >= 5'd1 && SIG_IN.chan <= 5'd15) begin
        reg_sel = 4'(SIG_IN.chan); // [R3]
        upper = 1'b1;
      end else begin
        reg_sel = 4'(SIG_IN.chan - 5'd15); // [R3]
      end
    end else if (SIG_IN.chan <= 5'd12) begin
      reg_sel = 4'(SIG_IN.chan - 5'd1); // [R3]
      upper = 1'b1;
    end else begin
      reg_sel = 4'(SIG_IN.chan - 5'd13); // [R3]
    end
    // Frozen during loss of sync so software sees the last good pattern
    if (SIG_IN.valid && !OUT_OF_FRAME) begin // [R6]
      if (st.mode.e1 && (SIG_IN.chan == 5'd0 || SIG_IN.chan > 5'd30)) begin
        next_st.sig = st.sig;
      end else if (!st.mode.e1 && (SIG_IN.chan == 5'd0 || SIG_IN.chan > 5'd24)) begin
        next_st.sig = st.sig;
      end else if (upper) begin
        next_st.sig[reg_sel][7:4] = abcd; // [R2]
      end else begin
        next_st.sig[reg_sel][3:0] = abcd; // [R2]
      end
    end
    if (st.mode.e1) begin
      next_st.sig[0][7:4] = 4'h0; // [R3]
    end
    next_st.line_cnt = sat_inc(st.line_cnt, EVT_IN.line_viol); // [R7]
    next_st.path_cnt = sat_inc(st.path_cnt, EVT_IN.path_viol); // [R8]
    next_st.sync_cnt = sat_inc(st.sync_cnt, EVT_IN.sync_loss); // [R9]
    next_st.ebit_cnt = sat_inc(st.ebit_cnt, EVT_IN.ebit_err && st.mode.e1); // [R10]
    next_st.fea_cnt = sat_inc(st.fea_cnt, EVT_IN.far_end_a); // [R12]
    // Milliwatt substitution; phase steps once per substituted byte
    next_st.rx_valid = RX_VALID;
    next_st.rx_data = RX_DATA;
    if (RX_VALID && !st.mode.e1 && RX_CHAN >= 5'd1 && RX_CHAN <= 5'd24) begin
      if (st.mw_en[RX_CHAN - 5'd1]) begin
        next_st.rx_data = rxsec_pkg::MILLIWATT_SEQ[{st.mw_phase, 3'b000} +: 8]; // [R1]
        next_st.mw_phase = st.mw_phase + 3'd1;
      end
    end
    // APB: one wait state, since ready comes from a flop to keep outputs registered
    next_st.pready = access_cyc && !st.pready;
    next_st.pslverr = 1'b0;
    if (access_cyc && !st.pready) begin
      if (idx >= rxsec_pkg::IDX_SIG_FIRST && idx <= rxsec_pkg::IDX_SIG_LAST) begin
        rd = st.sig[4'(idx - rxsec_pkg::IDX_SIG_FIRST)]; // [R2]
        rd_ok = !PWRITE;
      end else begin
        case (idx)
          rxsec_pkg::IDX_MW_CH1_8: rd = st.mw_en[7:0];
          rxsec_pkg::IDX_MW_CH9_16: rd = st.mw_en[15:8];
          rxsec_pkg::IDX_MW_CH17_24: rd = st.mw_en[23:16];
          rxsec_pkg::IDX_MODE: rd = {6'h00, st.mode};
          // Reading the high byte freezes the low byte for the following read
          rxsec_pkg::IDX_LINE_HI: begin
            rd = hi_byte(st.line_cnt); // [R7]
            next_st.lo_snap = lo_byte(st.line_cnt); // [R13]
          end
          rxsec_pkg::IDX_LINE_LO: rd = st.lo_snap; // [R7]
          rxsec_pkg::IDX_PATH_HI: begin
            rd = hi_byte(st.path_cnt); // [R8]
            next_st.lo_snap = lo_byte(st.path_cnt); // [R13]
          end
          rxsec_pkg::IDX_PATH_LO: rd = st.lo_snap; // [R8]
          rxsec_pkg::IDX_SYNC_HI: begin
            rd = hi_byte(st.sync_cnt); // [R9]
            next_st.lo_snap = lo_byte(st.sync_cnt); // [R13]
          end
          rxsec_pkg::IDX_SYNC_LO: rd = st.lo_snap; // [R9]
          rxsec_pkg::IDX_EBIT_HI: begin
            rd = hi_byte(st.ebit_cnt); // [R10]
            next_st.lo_snap = lo_byte(st.ebit_cnt); // [R13]
          end
          rxsec_pkg::IDX_EBIT_LO: rd = st.lo_snap; // [R10]
          rxsec_pkg::IDX_FEA_HI: begin
            rd = hi_byte(st.fea_cnt); // [R11]
            next_st.lo_snap = lo_byte(st.fea_cnt); // [R13]
          end
          rxsec_pkg::IDX_FEA_LO: rd = st.lo_snap; // [R12]
          default: rd_ok = 1'b0;
        endcase
        if (PWRITE) begin
          case (idx)
            rxsec_pkg::IDX_MW_CH1_8: next_st.mw_en[7:0] = PWDATA[7:0]; // [R1]
            rxsec_pkg::IDX_MW_CH9_16: next_st.mw_en[15:8] = PWDATA[7:0]; // [R1]
            rxsec_pkg::IDX_MW_CH17_24: next_st.mw_en[23:16] = PWDATA[7:0]; // [R1]
            rxsec_pkg::IDX_MODE: next_st.mode = rxsec_pkg::rxsec_mode_t'(PWDATA[1:0]);
            default: rd_ok = 1'b0;
          endcase
          next_st.lo_snap = st.lo_snap;
        end
      end
      next_st.prdata = PWRITE ? 32'h0000_0000 : {24'h000000, rd};
      next_st.pslverr = !rd_ok;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign RX_DATA_OUT = st.rx_data;
  assign RX_VALID_OUT = st.rx_valid;
  assign MODE = st.mode;

  sequence s_read(logic [7:0] i);
    PSEL && PENABLE && !PWRITE && !PREADY && idx == i;
  endsequence

  sequence s_write(logic [7:0] i);
    PSEL && PENABLE && PWRITE && !PREADY && idx == i;
  endsequence

  sequence s_sig_update(logic [4:0] c, logic [1:0] m);
    SIG_IN.valid && !OUT_OF_FRAME && SIG_IN.chan == c && st.mode == m;
  endsequence

  sequence s_rx_byte(logic [4:0] c);
    RX_VALID && !st.mode.e1 && RX_CHAN == c;
  endsequence

  a_sig_frozen: assert property ( // [R6]
    OUT_OF_FRAME && !st.mode.e1 |=> st.sig == $past(st.sig))
    else $error("signaling changed while out of frame");

  a_sig_frozen_e1: assert property ( // [R6]
    OUT_OF_FRAME && st.mode.e1 |=> st.sig == $past(st.sig))
    else $error("E1 signaling changed while out of frame");

  a_line_count: assert property ( // [R7]
    EVT_IN.line_viol && st.line_cnt != SAT |=> st.line_cnt == rxsec_cnt_t'($past(st.line_cnt) + 1'b1))
    else $error("line count did not step");

  a_line_idle: assert property ( // [R7]
    !EVT_IN.line_viol |=> st.line_cnt == $past(st.line_cnt))
    else $error("line count moved without event");

  a_path_count: assert property ( // [R8]
    !EVT_IN.path_viol |=> st.path_cnt == $past(st.path_cnt))
    else $error("path count moved without event");

  a_path_step: assert property ( // [R8]
    EVT_IN.path_viol && st.path_cnt != SAT |=> st.path_cnt == rxsec_cnt_t'($past(st.path_cnt) + 1'b1))
    else $error("path count did not step");

  a_sync_count: assert property ( // [R9]
    EVT_IN.sync_loss && st.sync_cnt != SAT |=> st.sync_cnt == rxsec_cnt_t'($past(st.sync_cnt) + 1'b1))
    else $error("sync loss count missed event");

  a_sync_idle: assert property ( // [R9]
    !EVT_IN.sync_loss |=> st.sync_cnt == $past(st.sync_cnt))
    else $error("sync loss count moved without event");

  a_ebit_t1: assert property ( // [R10]
    !st.mode.e1 |=> st.ebit_cnt == $past(st.ebit_cnt))
    else $error("ebit count moved in T1");

  a_ebit_step: assert property ( // [R10]
    EVT_IN.ebit_err && st.mode.e1 && st.ebit_cnt != SAT
    |=> st.ebit_cnt == rxsec_cnt_t'($past(st.ebit_cnt) + 1'b1))
    else $error("ebit count did not step in E1");

  a_fea_step: assert property ( // [R12]
    EVT_IN.far_end_a && st.fea_cnt != SAT |=> st.fea_cnt == rxsec_cnt_t'($past(st.fea_cnt) + 1'b1))
    else $error("far-end count did not step");

  a_fea_idle: assert property ( // [R12]
    !EVT_IN.far_end_a |=> st.fea_cnt == $past(st.fea_cnt))
    else $error("far-end count moved without event");

  a_count_sat: assert property ( // [R13]
    st.fea_cnt == SAT |=> st.fea_cnt == SAT)
    else $error("far-end count wrapped");

  a_line_sat: assert property ( // [R13]
    st.line_cnt == SAT |=> st.line_cnt == SAT)
    else $error("line count wrapped");

  a_hi_snapshot: assert property ( // [R11]
    s_read(rxsec_pkg::IDX_FEA_HI) |=> st.lo_snap == $past(st.fea_cnt[7:0]) && PREADY)
    else $error("snapshot not taken on high read");

  a_fea_hi_data: assert property ( // [R11]
    s_read(rxsec_pkg::IDX_FEA_HI) |=> PRDATA == {24'h000000, $past(st.fea_cnt[15:8])})
    else $error("far-end high byte read wrong");

  a_line_snapshot: assert property ( // [R13]
    s_read(rxsec_pkg::IDX_LINE_HI) |=> st.lo_snap == $past(st.line_cnt[7:0]))
    else $error("line snapshot not taken");

  a_path_snapshot: assert property ( // [R13]
    s_read(rxsec_pkg::IDX_PATH_HI) |=> st.lo_snap == $past(st.path_cnt[7:0]))
    else $error("path snapshot not taken");

  a_sync_snapshot: assert property ( // [R13]
    s_read(rxsec_pkg::IDX_SYNC_HI) |=> st.lo_snap == $past(st.sync_cnt[7:0]))
    else $error("sync loss snapshot not taken");

  a_ebit_snapshot: assert property ( // [R13]
    s_read(rxsec_pkg::IDX_EBIT_HI) |=> st.lo_snap == $past(st.ebit_cnt[7:0]))
    else $error("ebit snapshot not taken");

  a_line_lo_read: assert property ( // [R7]
    s_read(rxsec_pkg::IDX_LINE_LO) |=> PRDATA == {24'h000000, $past(st.lo_snap)})
    else $error("line low byte not from snapshot");

  a_fea_lo_read: assert property ( // [R12]
    s_read(rxsec_pkg::IDX_FEA_LO) |=> PRDATA == {24'h000000, $past(st.lo_snap)})
    else $error("far-end low byte not from snapshot");

  a_sig_read: assert property ( // [R2]
    s_read(rxsec_pkg::IDX_SIG_FIRST) |=> PRDATA == {24'h000000, $past(st.sig[0])})
    else $error("first signaling register read wrong");

  a_ro_write: assert property ( // [R7]
    s_write(rxsec_pkg::IDX_LINE_HI) |=> PSLVERR && PREADY)
    else $error("write to count register not refused");

  a_mw_write: assert property ( // [R1]
    s_write(rxsec_pkg::IDX_MW_CH1_8) |=> st.mw_en[7:0] == $past(PWDATA[7:0]))
    else $error("milliwatt enable write lost");

  a_apb_ready: assert property ( // [R2]
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready missing after access phase");

  a_ready_pulse: assert property ( // [R2]
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  a_e1_upper_zero: assert property ( // [R3]
    st.mode.e1 |=> st.sig[0][7:4] == 4'h0)
    else $error("E1 first signaling register upper nibble not zero");

  a_t1_upper: assert property ( // [R3]
    s_sig_update(5'd1, 2'b00) |=> st.sig[0][7:4] == $past(SIG_IN.abcd))
    else $error("T1 channel 1 not in upper nibble");

  a_t1_lower: assert property ( // [R3]
    s_sig_update(5'd13, 2'b00) |=> st.sig[0][3:0] == $past(SIG_IN.abcd))
    else $error("T1 channel 13 not in lower nibble");

  a_t1_last: assert property ( // [R3]
    s_sig_update(5'd24, 2'b00) |=> st.sig[11][3:0] == $past(SIG_IN.abcd))
    else $error("T1 channel 24 not in twelfth register");

  a_e1_first: assert property ( // [R3]
    s_sig_update(5'd1, 2'b01) |=> st.sig[1][7:4] == $past(SIG_IN.abcd))
    else $error("E1 channel 1 not in second register");

  a_e1_lower: assert property ( // [R3]
    s_sig_update(5'd16, 2'b01) |=> st.sig[1][3:0] == $past(SIG_IN.abcd))
    else $error("E1 channel 16 not in second register");

  a_d4_copy: assert property ( // [R4]
    s_sig_update(5'd2, 2'b10) |=> st.sig[1][7:4] == {2{$past(SIG_IN.abcd[3:2])}})
    else $error("D4 A and B not copied into C and D");

  a_milliwatt: assert property ( // [R1]
    s_rx_byte(5'd1) ##0 st.mw_en[0]
    |=> RX_DATA_OUT == rxsec_pkg::MILLIWATT_SEQ[{$past(st.mw_phase), 3'b000} +: 8])
    else $error("milliwatt output missing");

  a_mw_phase: assert property ( // [R1]
    s_rx_byte(5'd1) ##0 st.mw_en[0] |=> st.mw_phase == $past(st.mw_phase) + 3'd1)
    else $error("milliwatt phase did not step");

  a_mw_pass: assert property ( // [R1]
    s_rx_byte(5'd2) ##0 !st.mw_en[1] |=> RX_DATA_OUT == $past(RX_DATA))
    else $error("disabled channel data altered");

  a_rx_valid: assert property ( // [R1]
    RX_VALID |=> RX_VALID_OUT)
    else $error("receive valid not passed on");

endmodule

// *** sim/rxsec_line_model.sv ***
// Line-side model: signaling updates, error events and the receive byte stream
`timescale 1ns/1ps
module rxsec_line_model (
  input wire logic clk,
  input wire logic [7:0] rx_data_out,
  output rxsec_pkg::rxsec_sig_t sig = '0,
  output rxsec_pkg::rxsec_evt_t evt = '0,
  output logic out_of_frame = 1'b0,
  output logic [4:0] rx_chan = '0,
  output logic [7:0] rx_data = '0,
  output logic rx_valid = 1'b0
);
  // Released fields show inverted data, so stale values never look valid
  task automatic sig_send(input logic [4:0] c, input logic [3:0] abcd);
    @(posedge clk);
    sig <= '{chan: c, abcd: abcd, valid: 1'b1};
    @(posedge clk);
    sig <= '{chan: ~c, abcd: ~abcd, valid: 1'b0};
  endtask
  task automatic pulse(input logic [4:0] m, input int n);
    @(posedge clk);
    evt <= m;
    repeat (n - 1) @(posedge clk);
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic set_oof(input logic v);
    @(posedge clk);
    out_of_frame <= v;
  endtask
  task automatic rx_send(input logic [4:0] c, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    rx_chan <= c;
    rx_data <= d;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    @(negedge clk);
    q = rx_data_out;
  endtask
endmodule

// *** sim/rx_signaling_and_error_counters_bench.sv ***
// Self-checking bench for the receive signaling and error counter registers
`timescale 1ns/1ps
module rx_signaling_and_error_counters_bench;
  typedef struct {logic w; logic [7:0] idx, wd, exp; logic e;} rxsec_row_t;
  logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, rx_vout, out_of_frame, rx_valid;
  logic [7:0] rx_out, rx_data, q;
  logic [4:0] rx_chan;
  rxsec_pkg::rxsec_mode_t mode;
  rxsec_pkg::rxsec_sig_t sig;
  rxsec_pkg::rxsec_evt_t evt;
  int err_count = 0, compares = 0;
  rxsec_row_t rows[14] = '{
    '{1'b0, 8'h50, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h51, 8'h00, 8'h03, 1'b0},
    '{1'b0, 8'h52, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h53, 8'h00, 8'h02, 1'b0},
    '{1'b0, 8'h54, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h55, 8'h00, 8'h01, 1'b0},
    '{1'b0, 8'h58, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h59, 8'h00, 8'h04, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h96, 1'b0}, '{1'b0, 8'h4b, 8'h00, 8'h0a, 1'b0},
    '{1'b1, 8'h50, 8'h11, 8'h00, 1'b1}, '{1'b0, 8'h70, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'h3c, 8'h01, 8'h00, 1'b0}, '{1'b0, 8'h3c, 8'h00, 8'h01, 1'b0}};

  rxsec_top u_dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SIG_IN(sig), .OUT_OF_FRAME(out_of_frame), .EVT_IN(evt), .RX_CHAN(rx_chan),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_DATA_OUT(rx_out), .RX_VALID_OUT(rx_vout),
    .MODE(mode));
  rxsec_line_model u_line (.clk(clock), .rx_data_out(rx_out), .sig(sig), .evt(evt),
    .out_of_frame(out_of_frame), .rx_chan(rx_chan), .rx_data(rx_data), .rx_valid(rx_valid));

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits on the slave's own ready; the count only cuts a hang short
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("FAIL pready expected 1 seen %b", pready);
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("read data", {24'h0, exp}, rd);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    // Line 3, path 2, sync loss 1, far-end 4 events
    u_line.pulse(5'h1d, 1);
    u_line.pulse(5'h19, 1);
    u_line.pulse(5'h11, 1);
    u_line.pulse(5'h01, 1);
    u_line.sig_send(5'd1, 4'h9);
    u_line.sig_send(5'd13, 4'h6);
    u_line.sig_send(5'd24, 4'ha);
    // Host polls well inside the update interval of either framing
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd);
      chk("read data", {24'h0, rows[i].exp}, rd);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, err});
    end
    $display("table test done");
    u_line.rx_send(5'd1, 8'h55, q);
    chk("milliwatt", {24'h0, rxsec_pkg::MILLIWATT_SEQ[7:0]}, {24'h0, q});
    chk("rx valid out", 32'h1, {31'h0, rx_vout});
    u_line.rx_send(5'd2, 8'h55, q);
    chk("passthrough", 32'h55, {24'h0, q});
    apb(1'b1, rxsec_pkg::IDX_MODE, 8'h02);
    chk("mode", 32'h2, {30'h0, mode});
    u_line.sig_send(5'd2, 4'hc);
    rd_chk(8'h41, 8'hf0);
    u_line.set_oof(1'b1);
    u_line.sig_send(5'd2, 4'h4);
    rd_chk(8'h41, 8'hf0);
    u_line.set_oof(1'b0);
    $display("d4 and freeze test done");
    apb(1'b1, rxsec_pkg::IDX_MODE, 8'h01);
    u_line.sig_send(5'd1, 4'h5);
    u_line.sig_send(5'd16, 4'h7);
    u_line.pulse(5'h02, 2);
    rd_chk(8'h40, 8'h06);
    rd_chk(8'h41, 8'h57);
    u_line.set_oof(1'b1);
    u_line.sig_send(5'd16, 4'h3);
    rd_chk(8'h41, 8'h57);
    u_line.set_oof(1'b0);
    rd_chk(8'h56, 8'h00);
    rd_chk(8'h57, 8'h02);
    $display("e1 test done");
    rd_chk(8'h52, 8'h00);
    u_line.pulse(5'h08, 1);
    rd_chk(8'h53, 8'h02);
    u_line.pulse(5'h10, 65540);
    rd_chk(8'h50, 8'hff);
    rd_chk(8'h51, 8'hff);
    $display("saturation test done");
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(8'h50, 8'h00);
    rd_chk(8'h51, 8'h00);
    $display("reset test done");
    final_report();
  end
endmodule
